//--- logic/stm_timer.sv
// Notes on behaviour
// - Ten-bit up counter advances on each tick of the selected clock source.
// - Comparator P checks period code against counter bits 9..7; A checks all bits.
// - Software cannot write the counter; enable rising edge clears it to zero.
// - Counter clears on overflow or selected comparator match; all but the A-zero overflow raise a flag.
// - Pause bit holds counter value; clearing it resumes from held value.
// - Clock select picks sys/4, sys, high/16, high/64, sub, or pin edges.
// - Enable low stops counting and keeps value; rising enable zeroes counter.
// - Rising enable forces output to initial level in compare, capture, PWM or pulse modes.
// - Period code N matches after N*128 clocks; code zero means 1024.
// - Clear-select low: P match clears counter; code zero lets counter overflow.
// - Mode field: compare output, capture, PWM or pulse, timer/counter.
// - Timer/counter mode drives no defined output level.
// - Counter read-only and compare A read/write as low and high byte pairs.
// - One external input pin and one output pin.
// - Clear-select chooses P/overflow or A; ignored outside compare and timer modes.
// - Compare mode raises A flag, and P flag only with clear-select low; A zero overflows at 3FF without A flag.
// - Compare A match acts on output: none, low, high, toggle.
// - Polarity bit inverts output pin; no effect in timer/counter mode.
//
// Added by the designer: the register offsets and the APB slave port.
`default_nettype none
module stm_timer
  import stm_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic external_count_pin, // External count clock input
  output logic timer_io_pin_out, // Timer output level
  output logic timer_io_pin_oe // Output enable, high when driven
);
  stm_ctrl_a_t ctrl_a_reg;
  stm_ctrl_b_t ctrl_b_reg;
  logic [9:0] cmpa_reg;
  logic [9:0] count_reg;
  logic flag_a_reg;
  logic flag_p_reg;
  logic out_level_reg;
  logic enable_dly_reg;
  logic [7:0] div_reg;
  logic [1:0] pin_sync_reg;
  logic pin_last_reg;
  logic tick;
  logic enable_rise;
  logic match_p;
  logic match_a;
  logic clear_cnt;
  logic set_a;
  logic set_p;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_next;
  logic flag_clr_a;
  logic flag_clr_p;
  logic cmp_like;
  logic out_mode;
  logic step_ok;
  logic [9:0] cnt_inc;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign enable_rise = ctrl_a_reg.timer_enable & ~enable_dly_reg;
  assign cmp_like = (ctrl_b_reg.operating_mode_select == STM_MODE_CMP) ||
                    (ctrl_b_reg.operating_mode_select == STM_MODE_TMR);
  assign out_mode = ctrl_b_reg.operating_mode_select != STM_MODE_TMR;
  // Counting step: enabled, running, ticked and not the enable-clear cycle
  assign step_ok = tick & ctrl_a_reg.timer_enable & ~ctrl_a_reg.counter_pause & ~enable_rise;
  // Value the counter reaches on this tick
  assign cnt_inc = count_reg + 10'h001;

  // Address decode for mapped registers
  always_comb begin
    unique case (paddr)
      STM_CTRL_A_OFS, STM_CTRL_B_OFS, STM_CNT_LO_OFS, STM_CNT_HI_OFS,
      STM_CMPA_LO_OFS, STM_CMPA_HI_OFS, STM_FLAGS_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Write and control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_reg <= STM_CTRL_RST;
      ctrl_b_reg <= STM_CTRL_RST;
      cmpa_reg <= STM_CMPA_RST;
    end else if (wr_en) begin
      unique case (paddr)
        STM_CTRL_A_OFS: ctrl_a_reg <= pwdata[7:0];
        STM_CTRL_B_OFS: ctrl_b_reg <= pwdata[7:0];
        STM_CMPA_LO_OFS: cmpa_reg[7:0] <= pwdata[7:0];
        STM_CMPA_HI_OFS: cmpa_reg[9:8] <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Enable edge history
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enable_dly_reg <= 1'b0;
    end else begin
      enable_dly_reg <= ctrl_a_reg.timer_enable;
    end
  end

  // Free-running prescaler
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_sync_reg <= 2'b00;
      pin_last_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], external_count_pin};
      pin_last_reg <= pin_sync_reg[1];
    end
  end

  always_comb begin
    unique case (ctrl_a_reg.count_clock_select)
      STM_CK_SYS4: tick = div_reg[1:0] == 2'(STM_SYS_DIV - 1);
      STM_CK_SYS: tick = 1'b1;
      STM_CK_H16: tick = div_reg[3:0] == 4'(STM_H_DIV16 - 1);
      STM_CK_H64: tick = div_reg[5:0] == 6'(STM_H_DIV64 - 1);
      STM_CK_SUB0, STM_CK_SUB1: tick = div_reg == 8'(STM_SUB_DIV - 1);
      STM_CK_EXTR: tick = pin_sync_reg[1] & ~pin_last_reg;
      STM_CK_EXTF: tick = ~pin_sync_reg[1] & pin_last_reg;
    endcase
  end

  // comparators, period code
  // Match on the tick that reaches the value, so a period is code*128 ticks
  assign match_p = (ctrl_a_reg.period_code != 3'b000) && (cnt_inc[9:7] == ctrl_a_reg.period_code)
                   && (cnt_inc[6:0] == 7'h00);
  assign match_a = (cmpa_reg != 10'h000) && (cnt_inc == cmpa_reg);

  always_comb begin
    clear_cnt = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (cmp_like && !ctrl_b_reg.clear_source_select) begin
      clear_cnt = match_p || (ctrl_a_reg.period_code == 3'b000 && count_reg == STM_CNT_MAX);
      set_a = match_a;
      set_p = clear_cnt;
    end else if (cmp_like) begin
      clear_cnt = match_a || (cmpa_reg == 10'h000 && count_reg == STM_CNT_MAX);
      set_a = match_a;
    end else if (ctrl_b_reg.period_duty_swap) begin
      clear_cnt = match_a || (cmpa_reg == 10'h000 && count_reg == STM_CNT_MAX);
      set_a = match_a;
      set_p = match_p;
    end else begin
      clear_cnt = match_p || (ctrl_a_reg.period_code == 3'b000 && count_reg == STM_CNT_MAX);
      set_a = match_a;
      set_p = clear_cnt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 10'h000;
    end else if (enable_rise) begin
      count_reg <= 10'h000;
    end else if (ctrl_a_reg.timer_enable && !ctrl_a_reg.counter_pause && tick) begin
      count_reg <= clear_cnt ? 10'h000 : count_reg + 10'h001;
    end
  end

  // sticky flags, set wins over clear
  assign flag_clr_a = wr_en && paddr == STM_FLAGS_OFS && pwdata[STM_FLAG_A_BIT];
  assign flag_clr_p = wr_en && paddr == STM_FLAGS_OFS && pwdata[STM_FLAG_P_BIT];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      flag_a_reg <= (set_a & step_ok) | (flag_a_reg & ~flag_clr_a);
      flag_p_reg <= (set_p & step_ok) | (flag_p_reg & ~flag_clr_p);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_level_reg <= 1'b0;
    end else if (enable_rise && out_mode) begin
      out_level_reg <= ctrl_b_reg.output_initial_level;
    end else if (ctrl_b_reg.operating_mode_select == STM_MODE_CMP && set_a && step_ok) begin
      unique case (ctrl_b_reg.output_function_select)
        2'b00: out_level_reg <= out_level_reg;
        2'b01: out_level_reg <= 1'b0;
        2'b10: out_level_reg <= 1'b1;
        2'b11: out_level_reg <= ~out_level_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_io_pin_out <= 1'b0;
      timer_io_pin_oe <= 1'b0;
    end else begin
      timer_io_pin_out <= out_mode ? out_level_reg ^ ctrl_b_reg.output_polarity : 1'b0;
      timer_io_pin_oe <= ctrl_b_reg.operating_mode_select == STM_MODE_CMP ||
                         ctrl_b_reg.operating_mode_select == STM_MODE_PWM;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      STM_CTRL_A_OFS: rdata_next[7:0] = ctrl_a_reg;
      STM_CTRL_B_OFS: rdata_next[7:0] = ctrl_b_reg;
      STM_CNT_LO_OFS: rdata_next[7:0] = count_reg[7:0];
      STM_CNT_HI_OFS: rdata_next[1:0] = count_reg[9:8];
      STM_CMPA_LO_OFS: rdata_next[7:0] = cmpa_reg[7:0];
      STM_CMPA_HI_OFS: rdata_next[1:0] = cmpa_reg[9:8];
      STM_FLAGS_OFS: rdata_next[1:0] = {flag_p_reg, flag_a_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // APB answer registered, no wait state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & ~pwrite) ? rdata_next : prdata;
    end
  end

  enable_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    enable_rise |=> count_reg == 10'h000) else $error("counter not cleared on enable");
  hold_off_a: assert property (@(posedge clock) disable iff (!rstn)
    !ctrl_a_reg.timer_enable && !enable_rise |=> $stable(count_reg)) else $error("counter moved while off");
  pause_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_a_reg.counter_pause && !enable_rise |=> $stable(count_reg)) else $error("counter moved in pause");
  init_level_a: assert property (@(posedge clock) disable iff (!rstn)
    enable_rise && out_mode |=> out_level_reg == $past(ctrl_b_reg.output_initial_level))
    else $error("initial level not applied");
  count_step_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_a_reg.timer_enable && !ctrl_a_reg.counter_pause && tick && !clear_cnt && !enable_rise
    |=> count_reg == $past(count_reg) + 10'h001) else $error("counter step wrong");
  match_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    clear_cnt && step_ok |=> count_reg == 10'h000) else $error("counter not cleared");
  flag_a_set_a: assert property (@(posedge clock) disable iff (!rstn)
    set_a && step_ok |=> flag_a_reg) else $error("A flag missed");
  toggle_out_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_b_reg.operating_mode_select == STM_MODE_CMP && ctrl_b_reg.output_function_select == 2'b11
    && set_a && step_ok && !enable_rise |=> out_level_reg != $past(out_level_reg))
    else $error("toggle missed");
  // polarity, both terms taken from the cycle that launched the pin
  polarity_a: assert property (@(posedge clock) disable iff (!rstn)
    out_mode && $stable(ctrl_b_reg)
    |=> timer_io_pin_out == ($past(out_level_reg) ^ $past(ctrl_b_reg.output_polarity)))
    else $error("polarity wrong");
  tmr_undriven_a: assert property (@(posedge clock) disable iff (!rstn)
    !out_mode |=> !timer_io_pin_oe) else $error("pin driven in timer mode");
  // period clear on the last count of the period
  period_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    step_ok && cmp_like && !ctrl_b_reg.clear_source_select && ctrl_a_reg.period_code != 3'b000
    && count_reg[6:0] == 7'h7F && count_reg[9:7] == ctrl_a_reg.period_code - 3'h1
    |=> count_reg == 10'h000) else $error("period clear missed");
  ovf_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    step_ok && cmp_like && !ctrl_b_reg.clear_source_select && ctrl_a_reg.period_code == 3'b000
    && count_reg == STM_CNT_MAX
    |=> count_reg == 10'h000 && flag_p_reg) else $error("overflow clear missed");
  // no P flag under A clear
  no_p_flag_a: assert property (@(posedge clock) disable iff (!rstn)
    cmp_like && ctrl_b_reg.clear_source_select && !flag_p_reg |=> !flag_p_reg) else $error("P flag raised");
  // no A flag with zero compare
  zero_cmp_a: assert property (@(posedge clock) disable iff (!rstn)
    cmpa_reg == 10'h000 && !flag_a_reg |=> !flag_a_reg) else $error("A flag on zero compare");
  drive_low_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_b_reg.operating_mode_select == STM_MODE_CMP && ctrl_b_reg.output_function_select == 2'b01
    && set_a && step_ok |=> !out_level_reg) else $error("drive low missed");
  drive_high_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_b_reg.operating_mode_select == STM_MODE_CMP && ctrl_b_reg.output_function_select == 2'b10
    && set_a && step_ok |=> out_level_reg) else $error("drive high missed");
  ext_edge_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_a_reg.count_clock_select == STM_CK_EXTR && tick ##1 ctrl_a_reg.count_clock_select == STM_CK_EXTR
    |-> !tick) else $error("edge counted twice");
  a_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    step_ok && cmp_like && ctrl_b_reg.clear_source_select && cmpa_reg != 10'h000
    && count_reg == cmpa_reg - 10'h001 |=> count_reg == 10'h000) else $error("A clear missed");
  access_ready_a: assert property (@(posedge clock) disable iff (!rstn)
    psel && penable |-> pready) else $error("access without ready");
  read_data_a: assert property (@(posedge clock) disable iff (!rstn)
    rd_en |-> prdata == $past(rdata_next)) else $error("read data wrong");
  slverr_a: assert property (@(posedge clock) disable iff (!rstn)
    psel && penable |-> pslverr == !addr_ok) else $error("error response wrong");

  // Main scenarios
  p_match_c: cover property (@(posedge clock) disable iff (!rstn) set_p && step_ok);
  a_match_c: cover property (@(posedge clock) disable iff (!rstn) set_a && step_ok);
  ext_tick_c: cover property (@(posedge clock) disable iff (!rstn)
    ctrl_a_reg.count_clock_select == STM_CK_EXTR && tick);
  ovf_wrap_c: cover property (@(posedge clock) disable iff (!rstn)
    step_ok && clear_cnt && count_reg == STM_CNT_MAX);
  pwm_swap_c: cover property (@(posedge clock) disable iff (!rstn)
    ctrl_b_reg.operating_mode_select == STM_MODE_PWM && ctrl_b_reg.period_duty_swap && set_a && step_ok);
endmodule
`default_nettype wire

//--- shared/stm_pkg.sv
`default_nettype none
package stm_pkg;
  // Register word offsets (byte addresses)
  localparam logic [11:0] STM_CTRL_A_OFS = 12'h000;
  localparam logic [11:0] STM_CTRL_B_OFS = 12'h004;
  localparam logic [11:0] STM_CNT_LO_OFS = 12'h008;
  localparam logic [11:0] STM_CNT_HI_OFS = 12'h00C;
  localparam logic [11:0] STM_CMPA_LO_OFS = 12'h010;
  localparam logic [11:0] STM_CMPA_HI_OFS = 12'h014;
  localparam logic [11:0] STM_FLAGS_OFS = 12'h018;
  // Reset values and counter maximum
  localparam logic [7:0] STM_CTRL_RST = 8'h00;
  localparam logic [9:0] STM_CMPA_RST = 10'h000;
  localparam logic [9:0] STM_CNT_MAX = 10'h3FF;
  // Divider counts for internal sources
  localparam int STM_SYS_DIV = 4;
  localparam int STM_H_DIV16 = 16;
  localparam int STM_H_DIV64 = 64;
  localparam int STM_SUB_DIV = 256;
  // Flags register bit positions
  localparam int STM_FLAG_A_BIT = 0;
  localparam int STM_FLAG_P_BIT = 1;

  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'b00,
    STM_MODE_CAP = 2'b01,
    STM_MODE_PWM = 2'b10,
    STM_MODE_TMR = 2'b11
  } stm_mode_t;

  typedef enum logic [2:0] {
    STM_CK_SYS4 = 3'b000,
    STM_CK_SYS = 3'b001,
    STM_CK_H16 = 3'b010,
    STM_CK_H64 = 3'b011,
    STM_CK_SUB0 = 3'b100,
    STM_CK_SUB1 = 3'b101,
    STM_CK_EXTR = 3'b110,
    STM_CK_EXTF = 3'b111
  } stm_clk_sel_t;

  // Control register A layout
  typedef struct packed {
    logic counter_pause;
    stm_clk_sel_t count_clock_select;
    logic timer_enable;
    logic [2:0] period_code;
  } stm_ctrl_a_t;

  // Control register B layout
  typedef struct packed {
    stm_mode_t operating_mode_select;
    logic [1:0] output_function_select;
    logic output_initial_level;
    logic output_polarity;
    logic period_duty_swap;
    logic clear_source_select;
  } stm_ctrl_b_t;
endpackage
`default_nettype wire

//--- testbench/stm_timer_tb_top.sv
`default_nettype none
module stm_timer_tb_top
  import stm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ext = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_out;
  logic pin_oe;
  logic [31:0] d;
  logic [31:0] c1;
  logic [31:0] c2;
  logic er;
  logic [7:0] tb_b [4] = '{8'h09, 8'h19, 8'h21, 8'h3D};
  logic tb_i [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic tb_m [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  // System clock, 100 ns period
  always #50 clock = ~clock;

  stm_timer stm_timer_inst (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(ext), .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe)
  );

  // Verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer: setup, access until pready; only the bench timeout ends a wait
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] t;
    logic e;
    xfer(a, 1'b1, {24'h0, v}, t, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] t;
    logic x;
    xfer(a, 1'b0, 32'h0, t, x);
    check(nm, e, t);
  endtask

  task automatic rd_cnt(output logic [31:0] c);
    logic [31:0] lo;
    logic [31:0] hi;
    logic x;
    xfer(STM_CNT_LO_OFS, 1'b0, 32'h0, lo, x);
    xfer(STM_CNT_HI_OFS, 1'b0, 32'h0, hi, x);
    c = {22'h0, hi[1:0], lo[7:0]};
  endtask

  task automatic cnt_chk(input logic [31:0] e);
    logic [31:0] c;
    rd_cnt(c);
    check("counter", e, c);
  endtask

  // Pulses on the external pin, idle low
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      ext <= 1'b1;
      repeat (3) @(posedge clock);
      ext <= 1'b0;
      repeat (2) @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask

  // Off, set control B, then a rising enable
  task automatic start(input logic [7:0] ca, input logic [7:0] cb);
    wr(STM_CTRL_A_OFS, ca & 8'hF7);
    wr(STM_CTRL_B_OFS, cb);
    wr(STM_CTRL_A_OFS, ca);
    repeat (4) @(posedge clock);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(12'(4 * i), 32'h0, "reset value");
    end
    xfer(12'h01C, 1'b0, 32'h0, d, er);
    check("unmapped error", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, d);
    wr(STM_CNT_LO_OFS, 8'hFF);
    rd_chk(STM_CNT_LO_OFS, 32'h0, "counter write");
    wr(STM_CMPA_LO_OFS, 8'hA5);
    wr(STM_CMPA_HI_OFS, 8'hFF);
    rd_chk(STM_CMPA_LO_OFS, 32'hA5, "compare low");
    rd_chk(STM_CMPA_HI_OFS, 32'h3, "compare high");
    for (int i = 0; i < 8; i++) begin
      wr(STM_CTRL_A_OFS, {1'b0, 3'(i), 4'h0});
      rd_chk(STM_CTRL_A_OFS, {25'h0, 3'(i), 4'h0}, "clock select");
    end
    for (int m = 0; m < 4; m++) begin
      wr(STM_CTRL_B_OFS, {2'(m), 6'h0});
      repeat (3) @(posedge clock);
      check("output enable", 32'(m == 0 || m == 2), {31'h0, pin_oe});
    end
    // Pause holds, release resumes
    start(8'h18, 8'hC0);
    wr(STM_CTRL_A_OFS, 8'h98);
    rd_cnt(c1);
    repeat (10) @(posedge clock);
    rd_cnt(c2);
    check("paused count", c1, c2);
    wr(STM_CTRL_A_OFS, 8'h18);
    wr(STM_CTRL_A_OFS, 8'h98);
    rd_cnt(c2);
    check("resumed count", 32'h1, 32'(c2 > c1));
    // External edges, one count each
    start(8'h68, 8'hC0);
    pulse(5);
    cnt_chk(32'h5);
    wr(STM_CTRL_A_OFS, 8'h60);
    pulse(2);
    cnt_chk(32'h5);
    start(8'h78, 8'hC0);
    pulse(3);
    cnt_chk(32'h3);
    // Period code one, boundary at 128
    wr(STM_CMPA_HI_OFS, 8'h02);
    wr(STM_CMPA_LO_OFS, 8'h00);
    wr(STM_FLAGS_OFS, 8'h03);
    start(8'h69, 8'h00);
    pulse(127);
    cnt_chk(32'h7F);
    rd_chk(STM_FLAGS_OFS, 32'h0, "flags early");
    pulse(1);
    cnt_chk(32'h0);
    rd_chk(STM_FLAGS_OFS, 32'h2, "period flag");
    // Code zero runs to overflow
    start(8'h68, 8'h00);
    pulse(1023);
    cnt_chk(32'h3FF);
    pulse(1);
    cnt_chk(32'h0);
    // Output function table with compare A of 3
    wr(STM_CMPA_HI_OFS, 8'h00);
    wr(STM_CMPA_LO_OFS, 8'h03);
    wr(STM_FLAGS_OFS, 8'h03);
    for (int i = 0; i < 4; i++) begin
      start(8'h68, tb_b[i]);
      check("initial level", {31'h0, tb_i[i]}, {31'h0, pin_out});
      pulse(3);
      cnt_chk(32'h0);
      check("match level", {31'h0, tb_m[i]}, {31'h0, pin_out});
    end
    rd_chk(STM_FLAGS_OFS, 32'h1, "compare flag only");
    wr(STM_FLAGS_OFS, 8'h03);
    rd_chk(STM_FLAGS_OFS, 32'h0, "flags cleared");
    // PWM with swapped roles: compare A sets the period
    start(8'h68, 8'h82);
    check("pwm level", 32'h0, {31'h0, pin_out});
    pulse(3);
    cnt_chk(32'h0);
    rd_chk(STM_FLAGS_OFS, 32'h1, "swap flags");
    final_report();
  end
endmodule
`default_nettype wire
